// *** hw/cftc_defs.vh ***
`ifndef CFTC_DEFS_VH
`define CFTC_DEFS_VH
// ==========================================================
// register offsets (byte addresses)
`define CFTC_ADDR_MON_CTRL    8'h02
`define CFTC_ADDR_TMR_CTRL    8'h07
`define CFTC_ADDR_THERM_CTRL  8'h08
`define CFTC_ADDR_SWITCH_CTRL 8'h09
`define CFTC_ADDR_OPT_CTRL    8'h0a
`define CFTC_ADDR_STATUS      8'h0b
`define CFTC_ADDR_FAULT       8'h0c
// ==========================================================
// field positions
`define CFTC_MON_START_BIT    7
`define CFTC_MON_RATE_BIT     6
`define CFTC_TMR_HALF_BIT     7
`define CFTC_TMR_EN_BIT       3
`define CFTC_TMR_SEL_HI       2
`define CFTC_TMR_SEL_LO       1
`define CFTC_SW_DIS_BIT       5
`define CFTC_SW_DLY_BIT       3
`define CFTC_OPT_EN_BIT       0
`define CFTC_OPT_FORCE_BIT    1
// ==========================================================
// reset values
`define CFTC_RST_MON_CTRL     8'h00
`define CFTC_RST_TMR_CTRL     8'h8c
`define CFTC_RST_THERM_CTRL   8'h03
`define CFTC_RST_SWITCH_CTRL  8'h00
`define CFTC_RST_OPT_CTRL     8'h00
// ==========================================================
// charge fault codes
`define CFTC_CF_NONE          2'h0
`define CFTC_CF_INPUT_OV      2'h1
`define CFTC_CF_THERMAL       2'h2
`define CFTC_CF_TIMER         2'h3
// ==========================================================
// timing, figures in their own units
`define CFTC_CLK_KHZ          250000
`define CFTC_IRQ_PULSE_NS     250000
`define CFTC_BLINK_HALF_MS    500
`define CFTC_CONV_MS          1000
`define CFTC_SHIP_DLY_MS      12500
`define CFTC_PB_EXIT_MS       1750
`define CFTC_PB_RST_MS        15000
`define CFTC_RST_OFF_MS       450
`define CFTC_WAKE_TMR_HOURS   4
`endif

// *** hw/cftc_top.v ***
`timescale 1ns/1ps
`default_nettype none
`include "cftc_defs.vh"
module cftc_top #(
  parameter IRQ_CYC   = `CFTC_IRQ_PULSE_NS / 4,
  parameter MS_CYC    = `CFTC_CLK_KHZ,
  parameter HOUR_MS   = 3600000,
  parameter TMR_W     = 48
) (
  // clock and reset
  input  wire       sys_clk,
  input  wire       arst_n,
  // register port
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  // analog condition inputs
  input  wire       input_overvoltage,
  input  wire       sys_overvoltage,
  input  wire       sys_overcurrent,
  input  wire       thermal_over_limit,
  input  wire       thermal_shutdown,
  input  wire       battery_overvoltage,
  input  wire       vin_regulation,
  input  wire       iin_regulation,
  input  wire [2:0] thermistor_fault_field,
  input  wire       charging,
  input  wire       source_detected,
  input  wire       power_good,
  input  wire       above_battery,
  input  wire       source_removed,
  input  wire       above_vin_min,
  input  wire       charge_done,
  input  wire       conv_done,
  input  wire       push_button_n,
  // control outputs
  output reg        irq_out,
  output reg        irq_oe_n,
  output reg        stat_oe_n,
  output reg        converter_en,
  output reg        battery_switch,
  output reg        charge_en,
  output reg        current_reduce,
  output reg        termination_en,
  output reg        monitor_start_bit_pulse,
  output reg        optimizer_run,
  output reg        system_reset
);
  // ==========================================================
  // timing counts
  // widened first so the products cannot overflow 32 bits
  localparam [TMR_W-1:0] MS_W      = MS_CYC;
  localparam [TMR_W-1:0] IRQ_LEN   = IRQ_CYC;
  localparam [TMR_W-1:0] ONE       = {{(TMR_W-1){1'b0}}, 1'b1};
  localparam [TMR_W-1:0] BLINK_CYC = `CFTC_BLINK_HALF_MS * MS_W;
  localparam [TMR_W-1:0] CONV_CYC  = `CFTC_CONV_MS * MS_W;
  localparam [TMR_W-1:0] SHIP_CYC  = `CFTC_SHIP_DLY_MS * MS_W;
  localparam [TMR_W-1:0] PBX_CYC   = `CFTC_PB_EXIT_MS * MS_W;
  localparam [TMR_W-1:0] PBR_CYC   = `CFTC_PB_RST_MS * MS_W;
  localparam [TMR_W-1:0] ROFF_CYC  = `CFTC_RST_OFF_MS * MS_W;
  localparam [TMR_W-1:0] HOUR_CYC  = HOUR_MS * MS_W;
  // ==========================================================
  // input synchronisers: two flops per asynchronous line
  localparam NS = 18;
  wire [NS-1:0] raw = {push_button_n, conv_done, charge_done, above_vin_min,
                       source_removed, above_battery, power_good, source_detected,
                       charging, iin_regulation, vin_regulation, battery_overvoltage,
                       thermal_shutdown, thermal_over_limit, sys_overcurrent,
                       sys_overvoltage, input_overvoltage, 1'b0};
  reg  [NS-1:0] s1;
  reg  [NS-1:0] s2;
  reg  [2:0]    ntc1;
  reg  [2:0]    ntc2;
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      // button line idles high, so no false press after reset
      s1   <= {1'b1, {(NS-1){1'b0}}};
      s2   <= {1'b1, {(NS-1){1'b0}}};
      ntc1 <= 3'h0;
      ntc2 <= 3'h0;
    end else begin
      s1   <= raw;
      s2   <= s1;
      ntc1 <= thermistor_fault_field;
      ntc2 <= ntc1;
    end
  end
  wire       i_ov   = s2[1];
  wire       s_ov   = s2[2];
  wire       s_oc   = s2[3];
  wire       t_lim  = s2[4];
  wire       t_sd   = s2[5];
  wire       b_ov   = s2[6];
  wire       v_reg  = s2[7];
  wire       c_reg  = s2[8];
  wire       chg    = s2[9];
  wire [5:0] src_ev = s2[15:10];
  wire       done_s = s2[16];
  wire       pb_n   = s2[17];
  // rising edges of the source events
  reg  [5:0] ev_prev;
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) ev_prev <= 6'h00;
    else         ev_prev <= src_ev;
  end
  wire [5:0] ev_rise = src_ev & ~ev_prev;
  // ==========================================================
  // registers
  reg  [7:0] mon_ctrl;
  reg  [7:0] tmr_ctrl;
  reg  [7:0] therm_ctrl;
  reg  [7:0] sw_ctrl;
  reg  [7:0] opt_ctrl;
  reg        expired;
  reg        pb_exit;
  wire wr_mon = reg_wr && reg_addr == `CFTC_ADDR_MON_CTRL;
  wire rd_flt = reg_rd && reg_addr == `CFTC_ADDR_FAULT;
  reg        conv_clear;
  reg        force_clear;
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      mon_ctrl   <= `CFTC_RST_MON_CTRL;
      tmr_ctrl   <= `CFTC_RST_TMR_CTRL;
      therm_ctrl <= `CFTC_RST_THERM_CTRL;
      sw_ctrl    <= `CFTC_RST_SWITCH_CTRL;
      opt_ctrl   <= `CFTC_RST_OPT_CTRL;
    end else begin
      if (wr_mon) mon_ctrl <= reg_wdata;
      else if (conv_clear) mon_ctrl[`CFTC_MON_START_BIT] <= 1'b0;
      if (reg_wr && reg_addr == `CFTC_ADDR_TMR_CTRL)   tmr_ctrl   <= reg_wdata;
      if (reg_wr && reg_addr == `CFTC_ADDR_THERM_CTRL) therm_ctrl <= reg_wdata;
      if (reg_wr && reg_addr == `CFTC_ADDR_SWITCH_CTRL) sw_ctrl <= reg_wdata;
      else if (pb_exit) sw_ctrl[`CFTC_SW_DIS_BIT] <= 1'b0;
      if (reg_wr && reg_addr == `CFTC_ADDR_OPT_CTRL) opt_ctrl <= reg_wdata;
      else if (force_clear) opt_ctrl[`CFTC_OPT_FORCE_BIT] <= 1'b0;
    end
  end
  // ==========================================================
  // fault capture
  reg  [1:0] live_cf;
  always @* begin
    if (i_ov)          live_cf = `CFTC_CF_INPUT_OV;
    else if (t_sd)     live_cf = `CFTC_CF_THERMAL;
    else if (expired)  live_cf = `CFTC_CF_TIMER;
    else               live_cf = `CFTC_CF_NONE;
  end
  wire       live_any = (live_cf != `CFTC_CF_NONE) || b_ov;
  reg  [1:0] held_cf;
  reg        held_bov;
  reg        held_valid;
  reg        flt_block;
  reg        live_prev;
  wire       flt_new = live_any && !live_prev;
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      held_cf    <= 2'h0;
      held_bov   <= 1'b0;
      held_valid <= 1'b0;
      flt_block  <= 1'b0;
      live_prev  <= 1'b0;
    end else begin
      live_prev <= live_any;
      if (flt_new && !held_valid) begin
        // a new fault wins over a read in the same cycle when no fault is held
        held_cf    <= live_cf;
        held_bov   <= b_ov;
        held_valid <= 1'b1;
      end else if (rd_flt) begin
        held_valid <= 1'b0;
      end
      if (flt_new && !flt_block) flt_block <= 1'b1;
      else if (!held_valid && !live_any) flt_block <= 1'b0;
    end
  end
  wire flt_irq = flt_new && !flt_block;
  // ==========================================================
  // safety timer
  reg  [TMR_W-1:0] tmr_cnt;
  reg  [TMR_W-1:0] tmr_lim;
  reg              half_ph;
  wire             tmr_en = tmr_ctrl[`CFTC_TMR_EN_BIT];
  wire             slow = (v_reg || c_reg || t_lim)
                          && tmr_ctrl[`CFTC_TMR_HALF_BIT];
  always @* begin
    case (tmr_ctrl[`CFTC_TMR_SEL_HI:`CFTC_TMR_SEL_LO])
      2'h0:    tmr_lim = HOUR_CYC * 5;
      2'h1:    tmr_lim = HOUR_CYC * 8;
      2'h2:    tmr_lim = HOUR_CYC * 12;
      default: tmr_lim = HOUR_CYC * 20;
    endcase
  end
  wire [TMR_W-1:0] wake_lim = HOUR_CYC * `CFTC_WAKE_TMR_HOURS;
  reg              waking;
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      tmr_cnt <= {TMR_W{1'b0}};
      half_ph <= 1'b0;
      expired <= 1'b0;
      waking  <= 1'b1;
    end else if (!tmr_en || !chg) begin
      // expiry stays latched until the timer is disabled
      tmr_cnt <= {TMR_W{1'b0}};
      half_ph <= 1'b0;
      if (!tmr_en) expired <= 1'b0;
    end else if (!expired) begin
      half_ph <= ~half_ph;
      if (!slow || half_ph) tmr_cnt <= tmr_cnt + 1'b1;
      if (tmr_cnt >= (waking ? wake_lim : tmr_lim)) expired <= 1'b1;
    end
  end
  // ==========================================================
  // battery monitor sequencing
  reg [TMR_W-1:0] conv_cnt;
  wire            mon_start = mon_ctrl[`CFTC_MON_START_BIT];
  wire            mon_cont  = mon_ctrl[`CFTC_MON_RATE_BIT];
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      conv_cnt         <= {TMR_W{1'b0}};
      conv_clear       <= 1'b0;
      monitor_start_bit_pulse <= 1'b0;
    end else begin
      conv_clear <= 1'b0;
      monitor_start_bit_pulse <= 1'b0;
      // a pending clear must not start a second one-shot
      if (!mon_start || conv_clear) conv_cnt <= {TMR_W{1'b0}};
      else if (conv_cnt == {TMR_W{1'b0}}) begin
        monitor_start_bit_pulse <= 1'b1;
        conv_cnt <= conv_cnt + 1'b1;
      end else if (conv_cnt >= CONV_CYC || (done_s && !mon_cont)) begin
        conv_cnt <= {TMR_W{1'b0}};
        if (!mon_cont) conv_clear <= !wr_mon;
      end else conv_cnt <= conv_cnt + 1'b1;
    end
  end
  // ==========================================================
  // push button, shipping mode, switch
  reg [TMR_W-1:0] pb_cnt;
  reg [TMR_W-1:0] ship_cnt;
  reg [TMR_W-1:0] roff_cnt;
  reg             oc_latch;
  reg             sys_rst_act;
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pb_cnt      <= {TMR_W{1'b0}};
      ship_cnt    <= {TMR_W{1'b0}};
      roff_cnt    <= {TMR_W{1'b0}};
      oc_latch    <= 1'b0;
      pb_exit     <= 1'b0;
      sys_rst_act <= 1'b0;
    end else begin
      pb_exit <= 1'b0;
      if (pb_n) pb_cnt <= {TMR_W{1'b0}};
      else if (pb_cnt < PBR_CYC) pb_cnt <= pb_cnt + 1'b1;
      if (!pb_n && pb_cnt == PBX_CYC) pb_exit <= 1'b1;
      if (!pb_n && pb_cnt == PBR_CYC - 1'b1) begin
        sys_rst_act <= 1'b1;
        roff_cnt    <= {TMR_W{1'b0}};
      end else if (sys_rst_act) begin
        roff_cnt <= roff_cnt + 1'b1;
        if (roff_cnt >= ROFF_CYC - 1'b1) sys_rst_act <= 1'b0;
      end
      if (s_oc) oc_latch <= 1'b1;
      else if (pb_exit) oc_latch <= 1'b0;
      if (!sw_ctrl[`CFTC_SW_DIS_BIT]) ship_cnt <= {TMR_W{1'b0}};
      else if (ship_cnt < SHIP_CYC) ship_cnt <= ship_cnt + 1'b1;
    end
  end
  wire ship_off = sw_ctrl[`CFTC_SW_DIS_BIT] &&
                  (!sw_ctrl[`CFTC_SW_DLY_BIT] || ship_cnt >= SHIP_CYC);
  // ==========================================================
  // interrupt pulse
  reg [TMR_W-1:0] irq_cnt;
  wire            any_ev = (|ev_rise) || flt_irq;
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_cnt  <= {TMR_W{1'b0}};
      irq_oe_n <= 1'b1;
      irq_out  <= 1'b0;
    end else if (irq_cnt != {TMR_W{1'b0}}) begin
      irq_cnt <= irq_cnt - 1'b1;
      irq_oe_n <= (irq_cnt == ONE);
    end else if (any_ev) begin
      // line stays low for exactly IRQ_CYC cycles
      irq_cnt  <= IRQ_LEN;
      irq_oe_n <= 1'b0;
    end
  end
  // ==========================================================
  // status blink, power path, optimizer
  reg [TMR_W-1:0] blink_cnt;
  reg             blink;
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      blink_cnt      <= {TMR_W{1'b0}};
      blink          <= 1'b0;
      stat_oe_n      <= 1'b1;
      converter_en   <= 1'b0;
      battery_switch <= 1'b0;
      charge_en      <= 1'b0;
      current_reduce <= 1'b0;
      termination_en <= 1'b0;
      optimizer_run  <= 1'b0;
      force_clear    <= 1'b0;
      system_reset   <= 1'b0;
    end else begin
      if (blink_cnt >= BLINK_CYC - 1'b1) begin
        blink_cnt <= {TMR_W{1'b0}};
        blink     <= ~blink;
      end else blink_cnt <= blink_cnt + 1'b1;
      stat_oe_n <= live_any ? blink : !chg;
      converter_en   <= !i_ov && !s_ov && !t_sd;
      battery_switch <= !expired && !s_ov && !t_sd && !oc_latch && !ship_off
                        && !sys_rst_act;
      charge_en      <= !expired && !b_ov && !i_ov && !s_ov && !t_sd;
      current_reduce <= t_lim;
      termination_en <= !t_lim;
      system_reset   <= sys_rst_act;
      force_clear    <= opt_ctrl[`CFTC_OPT_FORCE_BIT];
      optimizer_run  <= opt_ctrl[`CFTC_OPT_FORCE_BIT] ||
                        (opt_ctrl[`CFTC_OPT_EN_BIT] && ev_rise[0]);
    end
  end
  // ==========================================================
  // read data, one cycle after strobe
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) reg_rdata <= 8'h00;
    else if (reg_rd) begin
      case (reg_addr)
        `CFTC_ADDR_MON_CTRL:    reg_rdata <= mon_ctrl;
        `CFTC_ADDR_TMR_CTRL:    reg_rdata <= tmr_ctrl;
        `CFTC_ADDR_THERM_CTRL:  reg_rdata <= therm_ctrl;
        `CFTC_ADDR_SWITCH_CTRL: reg_rdata <= sw_ctrl;
        `CFTC_ADDR_OPT_CTRL:    reg_rdata <= opt_ctrl;
        `CFTC_ADDR_STATUS:      reg_rdata <= {4'h0, oc_latch, expired, chg, t_lim};
        `CFTC_ADDR_FAULT:       reg_rdata <= held_valid ?
          {2'h0, held_cf, held_bov, ntc2} : {2'h0, live_cf, b_ov, ntc2};
        default:                reg_rdata <= 8'h00;
      endcase
    end
  end
endmodule // cftc_top
`default_nettype wire

// *** bench/cftc_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module cftc_chk #(
  parameter IRQ_CYC = 8
) (
  // clock, reset, register port
  input wire logic       sys_clk,
  input wire logic       arst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // conditions
  input wire logic       input_overvoltage,
  input wire logic       sys_overvoltage,
  input wire logic       sys_overcurrent,
  input wire logic       thermal_over_limit,
  input wire logic       thermal_shutdown,
  input wire logic       battery_overvoltage,
  // controls
  input wire logic       irq_out,
  input wire logic       irq_oe_n,
  input wire logic       converter_en,
  input wire logic       battery_switch,
  input wire logic       charge_en,
  input wire logic       current_reduce,
  input wire logic       termination_en,
  input wire logic       monitor_start_bit_pulse,
  input wire logic       system_reset
);
  logic [15:0] low_cnt;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // length of the current interrupt pulse
  always_ff @(posedge sys_clk or negedge arst_n)
    if (!arst_n) low_cnt <= 16'h0000;
    else if (irq_oe_n) low_cnt <= 16'h0000;
    else low_cnt <= low_cnt + 16'h0001;
  sequence held4(s);
    s [*4];
  endsequence
  irq_width_a: assert property ($rose(irq_oe_n) |-> low_cnt == IRQ_CYC)
    else $error("interrupt pulse width wrong");
  irq_data_a: assert property (irq_out == 1'b0)
    else $error("interrupt pin driven high");
  ov_stop_a: assert property (held4(input_overvoltage) |=> !converter_en)
    else $error("switching during input over-voltage");
  sysov_off_a: assert property (held4(sys_overvoltage) |=> !converter_en && !battery_switch)
    else $error("system over-voltage left power on");
  oc_off_a: assert property (held4(sys_overcurrent) |=> !battery_switch)
    else $error("switch on during over-current");
  thermal_limit_select_act_a: assert property (held4(thermal_over_limit) |=> current_reduce && !termination_en)
    else $error("thermal regulation not applied");
  tshut_off_a: assert property (held4(thermal_shutdown) |=> !converter_en && !battery_switch)
    else $error("thermal shutdown left power on");
  batov_stop_a: assert property (held4(battery_overvoltage) |=> !charge_en)
    else $error("charging during battery over-voltage");
  mon_start_a: assert property (reg_wr && reg_addr == 8'h02 && reg_wdata[7] |-> ##[1:4] monitor_start_bit_pulse)
    else $error("conversion not started");
  sw_off_a: assert property (reg_wr && reg_addr == 8'h09 && reg_wdata[5] && !reg_wdata[3]
    |-> ##[1:3] !battery_switch)
    else $error("switch not turned off at once");
  rst_off_a: assert property (system_reset && $past(system_reset) |-> !battery_switch)
    else $error("switch on during system reset");
  unmapped_rd_a: assert property (reg_rd && reg_addr == 8'h30 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule // cftc_chk
bind cftc_top cftc_chk #(.IRQ_CYC(IRQ_CYC)) chk_i (
  .sys_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .input_overvoltage, .sys_overvoltage, .sys_overcurrent, .thermal_over_limit,
  .thermal_shutdown, .battery_overvoltage, .irq_out, .irq_oe_n, .converter_en,
  .battery_switch, .charge_en, .current_reduce, .termination_en, .monitor_start_bit_pulse,
  .system_reset
);
`default_nettype wire

// *** bench/cftc_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module cftc_host (
  // pins seen by the host
  input  wire logic sys_clk,
  input  wire logic irq_out,
  input  wire logic irq_oe_n,
  input  wire logic stat_oe_n,
  // counts
  output var  int   irqs,
  output var  int   stat_edges
);
  // pulled-up open-drain lines
  wire logic irq_pin = irq_oe_n ? 1'b1 : irq_out;
  wire logic stat_pin = stat_oe_n;
  logic      irq_q = 1'b1;
  logic      stat_q = 1'b1;
  initial irqs = 0;
  initial stat_edges = 0;
  always @(posedge sys_clk) begin
    irq_q <= irq_pin;
    stat_q <= stat_pin;
    if (irq_q && !irq_pin)
      irqs <= irqs + 1;
    if (stat_q != stat_pin)
      stat_edges <= stat_edges + 1;
  end
endmodule // cftc_host
`default_nettype wire

// *** bench/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        sys_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [5:0]  prot = 6'h00;
  logic [5:0]  ev = 6'h00;
  logic [2:0]  ntc = 3'h0;
  logic        rgl = 1'b0;
  logic        charging = 1'b0;
  logic        conv_done = 1'b0;
  logic        pb_n = 1'b1;
  logic [31:0] seed = 32'hb15a;
  logic [7:0]  reg_rdata;
  logic [7:0]  d;
  logic        irq_out, irq_oe_n, stat_oe_n, converter_en;
  logic        battery_switch, monitor_start_bit_pulse, system_reset;
  int          irqs, stat_edges, n;
  int          convs = 0;
  int          fail_count = 0;
  int          checks = 0;
  logic [7:0]  ra [6] = '{8'h02, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h30};
  logic [7:0]  rv [6] = '{8'h00, 8'h8c, 8'h03, 8'h00, 8'h00, 8'h00};
  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) convs <= convs + int'(monitor_start_bit_pulse);
  cftc_top #(.IRQ_CYC(8), .MS_CYC(1), .HOUR_MS(16)) dut (
    .sys_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .input_overvoltage(prot[0]), .sys_overvoltage(prot[1]), .sys_overcurrent(prot[2]),
    .thermal_over_limit(prot[3]), .thermal_shutdown(prot[4]),
    .battery_overvoltage(prot[5]), .vin_regulation(rgl), .iin_regulation(rgl),
    .thermistor_fault_field(ntc), .charging, .source_detected(ev[0]), .power_good(ev[1]),
    .above_battery(ev[2]), .source_removed(ev[3]), .above_vin_min(ev[4]),
    .charge_done(ev[5]), .conv_done, .push_button_n(pb_n), .irq_out, .irq_oe_n,
    .stat_oe_n, .converter_en, .battery_switch, .charge_en(), .current_reduce(),
    .termination_en(), .monitor_start_bit_pulse, .optimizer_run(), .system_reset
  );
  cftc_host host (.sys_clk, .irq_out, .irq_oe_n, .stat_oe_n, .irqs, .stat_edges);
  // ==========================================================
  // helpers
  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  task automatic chk(logic [7:0] seen, logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(logic [7:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // waits for one pulse, or the whole span when none is due
  task automatic expect_irq(int lim, int e);
    n = irqs;
    repeat (lim) if (irqs == n || e == 0) @(posedge sys_clk);
    #1 chk(8'(irqs - n), 8'(e));
  endtask
  task automatic press(int k);
    pb_n <= 1'b0;
    cyc(k);
    pb_n <= 1'b1;
  endtask
  task automatic stop_test;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ==========================================================
  // scenarios
  initial begin
    cyc(6);
    arst_n <= 1'b1;
    cyc(1);
    for (int i = 0; i < 6; i++) begin
      rd(ra[i]);
      chk(d, rv[i]);
    end
    seed = xs(seed);
    wr(8'h30, seed[7:0]);
    rd(8'h30);
    chk(d, 8'h00);
    for (int i = 0; i < 6; i++) begin
      ev[i] <= 1'b1;
      expect_irq(40, 1);
      ev[i] <= 1'b0;
      expect_irq(20, 0);
    end
    seed = xs(seed);
    ntc <= seed[2:0];
    prot[0] <= 1'b1;
    expect_irq(40, 1);
    prot <= 6'h00;
    cyc(4);
    prot <= 6'h20;
    expect_irq(40, 0);
    prot <= 6'h00;
    cyc(4);
    rd(8'h0c);
    chk(d & 8'h37, {4'h1, 1'b0, ntc});
    rd(8'h0c);
    chk(d, {5'h00, ntc});
    prot[4] <= 1'b1;
    expect_irq(40, 1);
    chk({6'h00, converter_en, battery_switch}, 8'h00);
    prot[4] <= 1'b0;
    cyc(4);
    rd(8'h0c);
    chk(d & 8'h30, 8'h20);
    for (int i = 1; i < 4; i++) begin
      prot[i] <= 1'b1;
      cyc(10);
      prot[i] <= 1'b0;
    end
    cyc(10);
    chk({7'h00, battery_switch}, 8'h00);
    press(1800);
    chk({7'h00, battery_switch}, 8'h01);
    rd(8'h0c);
    rd(8'h0c);
    wr(8'h09, 8'h20);
    cyc(3);
    chk({7'h00, battery_switch}, 8'h00);
    wr(8'h09, 8'h00);
    press(1800);
    wr(8'h09, 8'h28);
    cyc(12400);
    chk({7'h00, battery_switch}, 8'h01);
    cyc(200);
    chk({7'h00, battery_switch}, 8'h00);
    wr(8'h09, 8'h00);
    press(1800);
    wr(8'h07, 8'h80);
    charging <= 1'b1;
    expect_irq(300, 0);
    charging <= 1'b0;
    wr(8'h07, 8'h88);
    rgl <= 1'b1;
    charging <= 1'b1;
    expect_irq(120, 0);
    expect_irq(400, 1);
    chk({6'h00, converter_en, battery_switch}, 8'h02);
    rd(8'h0c);
    chk(d & 8'h30, 8'h30);
    n = stat_edges;
    cyc(1100);
    chk({7'h00, stat_edges - n > 1}, 8'h01);
    charging <= 1'b0;
    rgl <= 1'b0;
    n = convs;
    wr(8'h02, 8'h80);
    conv_done <= 1'b1;
    cyc(4);
    conv_done <= 1'b0;
    rd(8'h02);
    chk(d, 8'h00);
    chk(8'(convs - n), 8'h01);
    wr(8'h02, 8'hc0);
    n = convs;
    cyc(2100);
    rd(8'h02);
    chk(d, 8'hc0);
    chk(8'(convs - n), 8'h03);
    wr(8'h02, 8'h00);
    n = convs;
    cyc(1100);
    chk(8'(convs - n), 8'h00);
    press(15040);
    chk({6'h00, system_reset, battery_switch}, 8'h02);
    cyc(460);
    chk({7'h00, system_reset}, 8'h00);
    stop_test;
  end
  initial begin
    repeat (60000) @(posedge sys_clk);
    fail_count++;
    stop_test;
  end
endmodule // testbench
`default_nettype wire
